// file: hdl/srm_defines.svh
/*
 * register offsets, field positions, masks, frame bit counts and the log depth of the
 * serial link receive status monitor.
 * assumes a 15-bit register address and 8-bit register data on the serial port.
 */
`ifndef SRM_DEFINES_SVH
`define SRM_DEFINES_SVH

// ****************************************************************
// per-link status and error registers (link-local offsets)
// ****************************************************************
`define SRM_ADDR_CODE_SYNC    9'h0a2
`define SRM_ADDR_FRAME_SYNC   9'h0a4
`define SRM_ADDR_BUF_STATE    9'h0a6
`define SRM_ADDR_ALIGN_LOCK   9'h0ee
`define SRM_ADDR_PLL_ALARM    9'h118
`define SRM_ADDR_LANE_SIGFIFO 9'h119
`define SRM_ADDR_RSVD_ALARM   9'h11a
`define SRM_ADDR_FS_ERROR     9'h11b
`define SRM_ADDR_LANE0_ERR    9'h11c
`define SRM_ADDR_LANE2_ERR    9'h11d
`define SRM_ADDR_LANE1_ERR    9'h11e
`define SRM_ADDR_LANE3_ERR    9'h11f

// ****************************************************************
// link windows, monitor configuration and event log registers
// ****************************************************************
`define SRM_LINK_SHIFT        9
`define SRM_ADDR_LANE_EN      15'h7f00
`define SRM_ADDR_MODE         15'h7f01
`define SRM_ADDR_CLEAR        15'h7f02
`define SRM_ADDR_LOG_LANE     15'h7f03
`define SRM_ADDR_LOG_FLAGS    15'h7f04
`define SRM_ADDR_LOG_STATUS   15'h7f05

// ****************************************************************
// field positions and constants
// ****************************************************************
`define SRM_BIT_SHORT_TEST    4
`define SRM_BIT_PAIR_AB_PLL   6
`define SRM_BIT_PAIR_CD_PLL   7
`define SRM_ERR64_ZERO_MASK   8'h08
`define SRM_BYTE_ZERO         8'h00
`define SRM_NIBBLE_ZERO       4'h0
`define SRM_HEAD_BITS         16
`define SRM_DATA_BITS         8
`define SRM_LOG_DEPTH         16

`endif

// file: hdl/srm_pkg.sv
/*
 * types shared by the serial link receive status monitor.
 * assumes nothing of its surroundings.
 */
package srm_pkg;
   typedef logic [7:0]  srm_byte_t;
   typedef logic [14:0] srm_addr_t;
   typedef enum { SPI_IDLE, SPI_HEAD, SPI_DATA, SPI_DONE } srm_spi_state_t;
endpackage

// file: hdl/srm_monitor.sv
/*
 * serial link receive status monitor: sticky serdes and lane alarms, live lane
 * state readback, an error event log fifo and a serial register port.
 * assumes the serial port clock runs at most one eighth of mclk and that all
 * status inputs come from recovered lane clocks (asynchronous to mclk).
 */
// Notes on behaviour
// - pll alarm byte: short test, ab, cd
// - loss of signal per lane, bits 0-3
// - serdes fifo error per lane, bits 4-7
// - frame sync or fixed ones error, bits 4-7
// - 8b10b lane bits 7-4: alignment, config, overflow
// - 8b10b bit 3: buffer match error
// - 8b10b bits 2-0: sync, table, disparity
// - 64b66b bits 7,6,4: alignment, overflow
// - 64b66b bit 5: crc command/data mismatch
// - 64b66b bit 3 zero, bit 2 alignment
// - 64b66b bit 1 bad header, bit 0 crc
// - lane error registers at scrambled offsets
// - four-bit alignment lock flags per link
// - two-bit code sync state per lane
// - two-bit frame sync state, 8b10b only
// - two-bit elastic buffer state per lane
// - second link replicates the whole link-local register set
// - sysref captured deterministically at both ends
// - scrambler setting matches at both ends
// - extended multiblock count agreed at both ends
// - same crc mode at both ends
// - alarms sticky until software clears them

// ****************************************************************
// event log fifo
// ****************************************************************
module srm_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wrPtr_reg;
   logic [AW-1:0]    rdPtr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign inReady  = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign outValid = (count_reg != '0);
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;
   assign outData  = mem_reg[rdPtr_reg];

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + AW'(1);
         end
         if (pop) begin
            rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + AW'(1);
         end
         if (push && !pop) begin
            count_reg <= count_reg + (AW+1)'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - (AW+1)'(1);
         end
      end
   end
endmodule // srm_fifo

// ****************************************************************
// monitor top
// ****************************************************************
module srm_monitor
   import srm_pkg::*;
#(
   parameter int NUM_LINKS = 2
) (
   // clock and reset
   input  wire logic                         mclk,
   input  wire logic                         rst,
   // serial register port
   input  wire logic                         spiSclk,
   input  wire logic                         spiCsN,
   input  wire logic                         spiSdi,
   output logic                              spiSdo,
   output logic                              spiSdoEn,
   // serdes alarms, one per link
   input  wire logic [NUM_LINKS-1:0]         shortTestAlarm,
   input  wire logic [NUM_LINKS-1:0]         pairAbPllUnlock,
   input  wire logic [NUM_LINKS-1:0]         pairCdPllUnlock,
   // lane status, four lanes per link, lane 0 lowest
   input  wire logic [NUM_LINKS*4-1:0]       laneLossOfSignal,
   input  wire logic [NUM_LINKS*4-1:0]       laneFifoError,
   input  wire logic [NUM_LINKS*4-1:0]       laneFrameSyncError,
   input  wire logic [NUM_LINKS*4-1:0]       alignLock,
   input  wire logic [NUM_LINKS*8-1:0]       extMultiblockState,
   input  wire logic [NUM_LINKS*8-1:0]       frameAlignmentState,
   input  wire logic [NUM_LINKS*8-1:0]       bufferState,
   input  wire logic [NUM_LINKS*32-1:0]      laneErrorEvent
);
   import srm_pkg::*;

   `include "srm_defines.svh"

   localparam int LANES = NUM_LINKS * 4;
   localparam int LW    = $clog2(LANES) > 0 ? $clog2(LANES) : 1;
   localparam int RAWW  = 3*NUM_LINKS + 4*LANES + 6*LANES + 8*LANES;

   // ****************************************************************
   // status synchroniser
   // ****************************************************************
   logic [RAWW-1:0]      rawStatus;
   logic [RAWW-1:0]      meta_reg;
   logic [RAWW-1:0]      sync_reg;
   logic [NUM_LINKS-1:0] sShort, sPllAb, sPllCd;
   logic [LANES-1:0]     sLos, sFifo, sFs, sLock;
   logic [2*LANES-1:0]   sCs, sFsState, sBuf;
   logic [8*LANES-1:0]   sErr;

   assign rawStatus = {laneErrorEvent, bufferState, frameAlignmentState, extMultiblockState, alignLock,
                       laneFrameSyncError, laneFifoError, laneLossOfSignal, pairCdPllUnlock, pairAbPllUnlock,
                       shortTestAlarm};
   assign {sErr, sBuf, sFsState, sCs, sLock, sFs, sFifo, sLos, sPllCd, sPllAb, sShort} = sync_reg;

   // only the second stage is read; lane clocks are unrelated to mclk
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= rawStatus;
         sync_reg <= meta_reg;
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   logic [LANES-1:0]     laneEnable_reg;
   logic [NUM_LINKS-1:0] mode64_reg;
   logic                 wrStrobe;
   srm_addr_t            wrAddr;
   srm_byte_t            wrData;
   logic [NUM_LINKS-1:0] clearLink;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         laneEnable_reg <= '1;
         mode64_reg     <= '0;
      end else if (wrStrobe) begin
         if (wrAddr == `SRM_ADDR_LANE_EN) begin
            laneEnable_reg <= LANES'(wrData);
         end
         if (wrAddr == `SRM_ADDR_MODE) begin
            mode64_reg <= NUM_LINKS'(wrData);
         end
      end
   end

   assign clearLink = (wrStrobe && wrAddr == `SRM_ADDR_CLEAR) ? NUM_LINKS'(wrData) : '0;

   // ****************************************************************
   // sticky alarms
   // ****************************************************************
   logic [NUM_LINKS-1:0] shortSticky_reg, pllAbSticky_reg, pllCdSticky_reg;
   logic [LANES-1:0]     losSticky_reg, fifoSticky_reg, fsSticky_reg;
   logic [7:0]           laneErr_reg [LANES];
   logic [7:0]           laneErrSet  [LANES];
   logic [LANES-1:0]     laneClear;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shortSticky_reg <= '0;
         pllAbSticky_reg <= '0;
         pllCdSticky_reg <= '0;
      end else begin
         shortSticky_reg <= (shortSticky_reg & ~clearLink) | sShort;
         pllAbSticky_reg <= (pllAbSticky_reg & ~clearLink) | sPllAb;
         pllCdSticky_reg <= (pllCdSticky_reg & ~clearLink) | sPllCd;
      end
   end

   genvar gl;
   generate
      for (gl = 0; gl < LANES; gl++) begin : g_lane
         assign laneClear[gl] = clearLink[gl/4];
         // 64b66b mode holds bit 3 at zero
         // sysref, multiblock count and crc mismatches at the far end surface here
         assign laneErrSet[gl] = laneEnable_reg[gl] ?
            (sErr[8*gl +: 8] & ~(mode64_reg[gl/4] ? `SRM_ERR64_ZERO_MASK : `SRM_BYTE_ZERO)) :
            `SRM_BYTE_ZERO;

         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               laneErr_reg[gl] <= '0;
            end else begin
               laneErr_reg[gl] <= (laneErr_reg[gl] & {8{~laneClear[gl]}}) | laneErrSet[gl];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         losSticky_reg  <= '0;
         fifoSticky_reg <= '0;
         fsSticky_reg   <= '0;
      end else begin
         losSticky_reg  <= (losSticky_reg & ~laneClear) | (sLos & laneEnable_reg);
         fifoSticky_reg <= (fifoSticky_reg & ~laneClear) | (sFifo & laneEnable_reg);
         fsSticky_reg   <= (fsSticky_reg & ~laneClear) | (sFs & laneEnable_reg);
      end
   end

   // ****************************************************************
   // error event log
   // ****************************************************************
   logic [7:0]      pend_reg [LANES];
   logic [LANES-1:0] pendAny;
   logic [LW-1:0]   pickLane;
   logic            logInValid, logInReady, logOutValid, logPop;
   logic [LW+7:0]   logInData, logOutData;

   function automatic logic [LW-1:0] firstSet(input logic [LANES-1:0] v);
      logic [LW-1:0] idx;
      idx = '0;
      for (int i = LANES - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = LW'(i);
         end
      end
      return idx;
   endfunction

   // a full log stalls the pending lanes; their flags keep accumulating
   generate
      for (gl = 0; gl < LANES; gl++) begin : g_pend
         assign pendAny[gl] = |pend_reg[gl];
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               pend_reg[gl] <= '0;
            end else if (logInValid && logInReady && pickLane == LW'(gl)) begin
               pend_reg[gl] <= laneErrSet[gl];
            end else begin
               pend_reg[gl] <= pend_reg[gl] | laneErrSet[gl];
            end
         end
      end
   endgenerate

   assign pickLane   = firstSet(pendAny);
   assign logInValid = |pendAny;
   assign logInData  = {pickLane, pend_reg[pickLane]};

   srm_fifo #(
      .WIDTH (LW + 8),
      .DEPTH (`SRM_LOG_DEPTH)
   ) u_log (
      .mclk     (mclk),
      .rst      (rst),
      .inValid  (logInValid),
      .inReady  (logInReady),
      .inData   (logInData),
      .outValid (logOutValid),
      .outReady (logPop),
      .outData  (logOutData)
   );

   // ****************************************************************
   // register read decode
   // ****************************************************************
   srm_addr_t rdAddr;
   srm_byte_t rdData;

   function automatic logic [7:0] expand2(input logic [3:0] en);
      return {{2{en[3]}}, {2{en[2]}}, {2{en[1]}}, {2{en[0]}}};
   endfunction

   always_comb begin
      int        lk;
      int        b;
      logic [3:0] en;
      rdData = `SRM_BYTE_ZERO;
      lk     = int'(rdAddr >> `SRM_LINK_SHIFT);
      b      = 4 * lk;
      en     = '0;
      if (rdAddr == `SRM_ADDR_LANE_EN) begin
         rdData = 8'(laneEnable_reg);
      end else if (rdAddr == `SRM_ADDR_MODE) begin
         rdData = 8'(mode64_reg);
      end else if (rdAddr == `SRM_ADDR_LOG_LANE) begin
         rdData = logOutValid ? 8'(logOutData[LW+7:8]) : `SRM_BYTE_ZERO;
      end else if (rdAddr == `SRM_ADDR_LOG_FLAGS) begin
         rdData = logOutValid ? logOutData[7:0] : `SRM_BYTE_ZERO;
      end else if (rdAddr == `SRM_ADDR_LOG_STATUS) begin
         rdData = {6'h00, ~logInReady, logOutValid};
      end else if (lk < NUM_LINKS) begin
         en = laneEnable_reg[b +: 4];
         case (rdAddr[`SRM_LINK_SHIFT-1:0])
            `SRM_ADDR_CODE_SYNC: begin
               rdData = sCs[2*b +: 8] & expand2(en);
            end
            `SRM_ADDR_FRAME_SYNC: begin
               rdData = mode64_reg[lk] ? `SRM_BYTE_ZERO : (sFsState[2*b +: 8] & expand2(en));
            end
            `SRM_ADDR_BUF_STATE: begin
               rdData = sBuf[2*b +: 8] & expand2(en);
            end
            `SRM_ADDR_ALIGN_LOCK: begin
               rdData = {`SRM_NIBBLE_ZERO, sLock[b +: 4] & en};
            end
            `SRM_ADDR_PLL_ALARM: begin
               rdData = `SRM_BYTE_ZERO;
               rdData[`SRM_BIT_SHORT_TEST]  = shortSticky_reg[lk];
               rdData[`SRM_BIT_PAIR_AB_PLL] = pllAbSticky_reg[lk];
               rdData[`SRM_BIT_PAIR_CD_PLL] = pllCdSticky_reg[lk];
            end
            `SRM_ADDR_LANE_SIGFIFO: begin
               rdData = {fifoSticky_reg[b +: 4], losSticky_reg[b +: 4]};
            end
            `SRM_ADDR_RSVD_ALARM: begin
               rdData = `SRM_BYTE_ZERO;
            end
            `SRM_ADDR_FS_ERROR: begin
               rdData = {fsSticky_reg[b +: 4], `SRM_NIBBLE_ZERO};
            end
            `SRM_ADDR_LANE0_ERR: begin
               rdData = laneErr_reg[b];
            end
            `SRM_ADDR_LANE1_ERR: begin
               rdData = laneErr_reg[b + 1];
            end
            `SRM_ADDR_LANE2_ERR: begin
               rdData = laneErr_reg[b + 2];
            end
            `SRM_ADDR_LANE3_ERR: begin
               rdData = laneErr_reg[b + 3];
            end
            default: begin
               rdData = `SRM_BYTE_ZERO;
            end
         endcase
      end
   end

   // ****************************************************************
   // serial register port
   // ****************************************************************
   srm_spi_state_t spiState_reg;
   logic           sclkPrev_reg;
   logic [15:0]    headShift_reg;
   logic [7:0]     outShift_reg;
   logic [7:0]     inShift_reg;
   logic [4:0]     bitCnt_reg;
   logic           isRead_reg;
   logic           dataStarted_reg;
   srm_addr_t      addr_reg;
   logic           sclkRise, sclkFall;
   logic [15:0]    headNow;

   assign sclkRise = spiSclk & ~sclkPrev_reg;
   assign sclkFall = ~spiSclk & sclkPrev_reg;
   assign headNow  = {headShift_reg[14:0], spiSdi};
   assign rdAddr   = (spiState_reg == SPI_HEAD) ? srm_addr_t'(headNow[14:0]) : addr_reg;
   assign spiSdo   = outShift_reg[7];
   assign spiSdoEn = (spiState_reg == SPI_DATA) & isRead_reg & ~spiCsN;
   // popping at the header keeps the log head and its lane index paired per read
   assign logPop   = (spiState_reg == SPI_HEAD) && sclkRise && !spiCsN && bitCnt_reg == 5'(`SRM_HEAD_BITS - 1)
                     && headNow[15] && rdAddr == `SRM_ADDR_LOG_FLAGS;
   assign wrStrobe = (spiState_reg == SPI_DATA) && sclkRise && !spiCsN && !isRead_reg
                     && bitCnt_reg == 5'(`SRM_DATA_BITS - 1);
   assign wrAddr   = addr_reg;
   assign wrData   = {inShift_reg[6:0], spiSdi};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclkPrev_reg <= 1'b0;
      end else begin
         sclkPrev_reg <= spiSclk;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         spiState_reg    <= SPI_IDLE;
         headShift_reg   <= '0;
         outShift_reg    <= '0;
         inShift_reg     <= '0;
         bitCnt_reg      <= '0;
         isRead_reg      <= 1'b0;
         dataStarted_reg <= 1'b0;
         addr_reg        <= '0;
      end else if (spiCsN) begin
         spiState_reg    <= SPI_IDLE;
         bitCnt_reg      <= '0;
         dataStarted_reg <= 1'b0;
      end else begin
         case (spiState_reg)
            SPI_IDLE: begin
               spiState_reg <= SPI_HEAD;
               bitCnt_reg   <= '0;
            end
            SPI_HEAD: begin
               if (sclkRise) begin
                  headShift_reg <= headNow;
                  bitCnt_reg    <= bitCnt_reg + 5'(1);
                  if (bitCnt_reg == 5'(`SRM_HEAD_BITS - 1)) begin
                     isRead_reg   <= headNow[15];
                     addr_reg     <= srm_addr_t'(headNow[14:0]);
                     outShift_reg <= rdData;
                     bitCnt_reg   <= '0;
                     spiState_reg <= SPI_DATA;
                  end
               end
            end
            SPI_DATA: begin
               if (sclkRise) begin
                  dataStarted_reg <= 1'b1;
                  inShift_reg     <= wrData;
                  bitCnt_reg      <= bitCnt_reg + 5'(1);
                  if (bitCnt_reg == 5'(`SRM_DATA_BITS - 1)) begin
                     spiState_reg <= SPI_DONE;
                  end
               end else if (sclkFall && dataStarted_reg) begin
                  outShift_reg <= {outShift_reg[6:0], 1'b0};
               end
            end
            SPI_DONE: begin
               spiState_reg <= SPI_DONE;
            end
            default: begin
               spiState_reg <= SPI_IDLE;
            end
         endcase
      end
   end
endmodule // srm_monitor

// file: hdl/srm_monitor_tail.sv
/*
 * holds no logic: the monitor and its log fifo share one design file.
 * assumes nothing of its surroundings.
 */

// file: bench/srm_spi_monitor.sv
/* serial port timing checker for the status monitor.
   assumes it is bound to the monitor top and sees only its ports. */
module srm_spi_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // serial register port
   input wire logic spiSclk,
   input wire logic spiCsN,
   input wire logic spiSdo,
   input wire logic spiSdoEn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sclkQ;
   logic [4:0] riseCnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ****************************************
   // sclk rises seen within the current frame
   // ****************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclkQ   <= 1'b0;
         riseCnt <= 5'h00;
      end else begin
         sclkQ <= spiSclk;
         if (spiCsN) riseCnt <= 5'h00;
         else if (spiSclk && !sclkQ) riseCnt <= riseCnt + 5'h01;
      end
   end
   csIdle_noDrive_a: assert property (spiCsN [*2] |-> !spiSdoEn) else $error("sdo driven while idle");
   header_noDrive_a: assert property (!spiCsN && riseCnt < 5'h10 |-> !spiSdoEn) else $error("early drive");
   readStart_a:
      assert property ($rose(spiSdoEn) |-> !spiCsN && spiSclk && riseCnt == 5'h10)
      else $error("read data started off the sixteenth rise");
   readHold_a: assert property ($rose(spiSdoEn) |-> (spiSdoEn || spiCsN) [*8]) else $error("drive cut short");
   shiftOnLow_a:
      assert property (spiSdoEn && $past(spiSdoEn) && riseCnt != 5'h10 && !$stable(spiSdo) |-> !spiSclk)
      else $error("sdo moved while sclk high");
   readEnd_a:
      assert property ($fell(spiSdoEn) && !spiCsN |-> spiSclk && riseCnt == 5'h18)
      else $error("drive ended off the last rise");
   csRise_release_a: assert property ($rose(spiCsN) |-> ##[0:2] !spiSdoEn) else $error("drive held after cs");
   driveInFrame_a: assert property (spiSdoEn |-> !spiCsN || !$past(spiCsN)) else $error("drive outside frame");
   cover property ($rose(spiSdoEn));
   cover property ($fell(spiSdoEn));
   cover property ($rose(spiCsN));
endmodule // srm_spi_chk

bind srm_monitor srm_spi_chk chk (.mclk(mclk), .rst(rst), .spiSclk(spiSclk), .spiCsN(spiCsN),
   .spiSdo(spiSdo), .spiSdoEn(spiSdoEn));

// file: bench/srm_far_end.sv
/* far-end transmitter model: lane lock and state machine values.
   assumes up is driven by the bench; lanes only settle while data flows. */
module srm_far_end #(
   parameter int NL = 2
) (
   // clock and control
   input wire logic        mclk,
   input wire logic        up,
   // lane status seen at the receiver
   output logic [NL*4-1:0] laneLos,
   output logic [NL*4-1:0] lock,
   output logic [NL*8-1:0] emb,
   output logic [NL*8-1:0] fsSt,
   output logic [NL*8-1:0] bufSt
);
   timeunit 1ns;
   timeprecision 1ps;
   // sysref, scrambler, crc mode and multiblock count taken as equal at both ends
   always @(negedge mclk) begin
      laneLos <= {NL*4{!up}};
      lock    <= {NL*4{up}};
      emb     <= up ? {NL*4{2'b10}} : '0;
      fsSt    <= up ? {NL*4{2'b01}} : '0;
      bufSt   <= up ? {NL*4{2'b11}} : '0;
   end
endmodule // srm_far_end

// file: bench/serial_link_rx_status_monitor_tb.sv
/* self-checking bench: register reads over the serial port against expectations.
   assumes srm_monitor with two links and the far-end model. */
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module serial_link_rx_status_monitor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, rst = 1, spiSclk = 0, spiCsN = 1, spiSdi = 0, up = 0, spiSdo, spiSdoEn;
   logic [1:0]  stAl = '0, abAl = '0, cdAl = '0;
   logic [7:0]  fifoErr = '0, fsErr = '0, los, lock, rb, ex;
   logic [15:0] emb, fst, bst;
   logic [63:0] evt = '0;
   logic [31:0] r;
   logic [7:0]  q[$];
   logic [7:0]  v[17];
   int          mismatches = 0, n_tests = 0, nb = 0;
   always #5 mclk = ~mclk;
   srm_monitor #(.NUM_LINKS(2)) dut (.mclk(mclk), .rst(rst), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdi(spiSdi),
      .spiSdo(spiSdo), .spiSdoEn(spiSdoEn), .shortTestAlarm(stAl), .pairAbPllUnlock(abAl), .pairCdPllUnlock(cdAl),
      .laneLossOfSignal(los), .laneFifoError(fifoErr), .laneFrameSyncError(fsErr), .alignLock(lock),
      .extMultiblockState(emb), .frameAlignmentState(fst), .bufferState(bst), .laneErrorEvent(evt));
   srm_far_end #(.NL(2)) far (.mclk(mclk), .up(up), .laneLos(los), .lock(lock), .emb(emb), .fsSt(fst), .bufSt(bst));
   // ****************************************
   // serial port tasks
   // ****************************************
   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic xfer(input logic rdn, input logic [14:0] a, input logic [7:0] d);
      logic [23:0] f;
      f = {rdn, a, d};
      spiCsN = 0;
      for (int i = 23; i >= 0; i--) begin
         spiSdi = f[i];
         hold(4);
         spiSclk = 1;
         hold(4);
         spiSclk = 0;
      end
      hold(2);
      spiCsN = 1;
      hold(3);
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      q.push_back(e);
      xfer(1'b1, a, 8'h00);
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      xfer(1'b0, a, d);
   endtask
   task automatic results;
      if (q.size() != 0) mismatches++;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // read data is taken at each sclk rise while the device drives
   always @(posedge spiSclk) begin
      if (spiSdoEn === 1'b1) begin
         rb = {rb[6:0], spiSdo};
         nb++;
         if (nb == 8) begin
            nb = 0;
            // pop once: the macro names its expected value twice
            ex = q.pop_front();
            `CHK(rb, ex)
         end
      end
   end
   initial begin
      repeat (100000) @(posedge mclk);
      mismatches++;
      results();
   end
   initial begin
      void'($urandom(32'h04e000fa));
      hold(16);
      rst = 0;
      hold(2);
      rd(15'h7f00, 8'hff);
      rd(15'h7f05, 8'h00);
      rd(15'h0118, 8'h00);
      rd(15'h011a, 8'h00);
      rd(15'h0119, 8'h0f);
      rd(15'h00ee, 8'h00);
      $display("test reset done");
      up = 1;
      hold(8);
      rd(15'h0119, 8'h0f);
      wr(15'h7f02, 8'h03);
      rd(15'h0119, 8'h00);
      rd(15'h00ee, 8'h0f);
      rd(15'h00a2, 8'haa);
      rd(15'h00a4, 8'h55);
      rd(15'h00a6, 8'hff);
      rd(15'h02ee, 8'h0f);
      $display("test link up done");
      for (int i = 0; i < 17; i++) begin
         v[i] = 8'($urandom) | 8'h01;
         evt[15:8] = v[i];
         // one mclk only: every cycle an event stands is logged again
         hold(1);
         evt[15:8] = 8'h00;
         hold(8);
      end
      rd(15'h7f05, 8'h03);
      for (int i = 0; i < 17; i++) begin
         rd(15'h7f03, 8'h01);
         rd(15'h7f04, v[i]);
      end
      rd(15'h7f05, 8'h00);
      wr(15'h7f02, 8'h01);
      $display("test log done");
      r = $urandom;
      {fsErr, fifoErr, cdAl, abAl, stAl} = {r[23:8], r[5:0]};
      hold(4);
      {fsErr, fifoErr, cdAl, abAl, stAl} = '0;
      hold(4);
      rd(15'h0118, {r[4], r[2], 1'b0, r[0], 4'h0});
      rd(15'h0318, {r[5], r[3], 1'b0, r[1], 4'h0});
      rd(15'h0119, {r[11:8], 4'h0});
      rd(15'h011b, {r[19:16], 4'h0});
      wr(15'h7f02, 8'h03);
      r = $urandom;
      evt[31:0] = r;
      hold(4);
      evt = '0;
      hold(4);
      rd(15'h011c, r[7:0]);
      rd(15'h011e, r[15:8]);
      rd(15'h011d, r[23:16]);
      rd(15'h011f, r[31:24]);
      wr(15'h7f02, 8'h01);
      rd(15'h011c, 8'h00);
      $display("test alarms done");
      wr(15'h7f01, 8'h01);
      r = $urandom;
      evt[7:0] = r[7:0];
      hold(4);
      evt = '0;
      hold(4);
      rd(15'h011c, r[7:0] & 8'hf7);
      rd(15'h00a4, 8'h00);
      wr(15'h7f01, 8'h00);
      wr(15'h7f02, 8'h01);
      wr(15'h7f00, 8'hfe);
      wr(15'h00ee, 8'h00);
      rd(15'h00ee, 8'h0e);
      rd(15'h00a2, 8'ha8);
      rd(15'h00a6, 8'hfc);
      evt[7:0] = 8'hff;
      hold(4);
      evt = '0;
      hold(4);
      rd(15'h011c, 8'h00);
      $display("test modes done");
      results();
   end
endmodule // serial_link_rx_status_monitor_tb
